// >>> hdl/dgt_edge_sync.sv
`default_nettype none

module dgt_edge_sync (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic meta;
    logic sync;
    logic prev;
    logic [1:0] fill;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            fill <= 2'h0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
            fill <= (fill == 2'h3) ? fill : fill + 2'h1;
        end
    end

    // edges only from the third clock after reset onward
    // pin may idle high, so no edge until prev holds a real level
    assign level_o = sync;
    assign rise_o = sync & ~prev & (fill == 2'h3);
    assign fall_o = ~sync & prev & (fill == 2'h3);

endmodule // dgt_edge_sync

`default_nettype wire

// >>> hdl/dgt_pkg.sv
`default_nettype none

package dgt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TRIG_DELAY_NS = 2000;
    localparam int TRIG_DELAY_CYC = (TRIG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_WAITS = 2;
    localparam int STEP_LAST = 6;
    localparam int STEP_NS [0:6] = '{25600, 32000, 38400, 44800, 204800, 256000, 307200};
    localparam int CNT_W = 20;

    ////////////////////////////////////////////////////////////////////////////
    // widths and codes
    localparam int CODE_W = 10;
    localparam int RESOLUTION_DEF = 10;

    localparam logic [2:0] FS_PD_HIZ = 3'h0;
    localparam logic [2:0] FS_PD_RGND = 3'h1;
    localparam logic [2:0] FS_MARGIN = 3'h2;
    localparam logic [2:0] FS_FUNCGEN = 3'h3;
    localparam logic [2:0] FS_ALARM_HI = 3'h4;
    localparam logic [2:0] FS_ALARM_MED = 3'h5;
    localparam logic [2:0] FS_ALARM_LO = 3'h6;
    localparam logic [2:0] FS_ADDR = 3'h7;

    localparam logic [1:0] PDN_ON = 2'h0;
    localparam logic [1:0] PDN_RGND = 2'h1;
    localparam logic [1:0] PDN_HIZ = 2'h2;

    localparam logic [1:0] MRG_NONE = 2'h0;
    localparam logic [1:0] MRG_HIGH = 2'h1;
    localparam logic [1:0] MRG_LOW = 2'h2;

    localparam logic [1:0] ALM_NONE = 2'h0;
    localparam logic [1:0] ALM_LO = 2'h1;
    localparam logic [1:0] ALM_MED = 2'h2;
    localparam logic [1:0] ALM_HI = 2'h3;

    localparam logic [2:0] GAIN_1X = 3'h0;
    localparam logic [2:0] GAIN_1P5X = 3'h1;
    localparam logic [2:0] GAIN_2X = 3'h2;
    localparam logic [2:0] GAIN_3X = 3'h3;
    localparam logic [2:0] GAIN_4X = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [9:0] RST_CODE = 10'h000;
    localparam logic [1:0] RST_PDN = PDN_HIZ;
    localparam logic [2:0] RST_GAIN = GAIN_1X;

    typedef enum logic [1:0] {BOOT_LOAD, BOOT_SAMPLE, BOOT_RUN} dgt_boot_t;

endpackage : dgt_pkg

`default_nettype wire

// >>> hdl/dgt_trigger_ctrl.sv
// Functional notes
// [RQ1] host drives the serial port no faster than standard, fast or fast-plus rate
// [RQ2] after reset all converter settings load from nonvolatile memory first
// [RQ3] output starts high impedance unless stored mode picks resistive to ground
// [RQ4] output code is unsigned binary from zero to two to the N minus one
// [RQ5] supply reference is default and always gives unity gain
// [RQ6] internal reference is off after reset, enabled by its config bit
// [RQ7] with internal reference, gain select picks 1.5, 2, 3 or 4 times
// [RQ8] trigger enable low makes the trigger pin cause nothing at all
// [RQ9] after boot only pin edges act, never the steady level
// [RQ10] at power-up the pin level is sampled and its command executed
// [RQ11] software command of the function mapped to the pin is ignored
// [RQ12] pin margin requests take effect dynamically, other constraints still hold
// [RQ13] 000 and 001 power up on rise, power down on fall
// [RQ14] 010 margins high or low, 011 starts or stops function generation
// [RQ15] 100 starts or stops the high-priority alarm
// [RQ16] 101 starts or stops the medium-priority alarm
// [RQ17] 110 starts or stops the low-priority alarm
// [RQ18] 111 rise allows address updates, fall blocks them
// [RQ19] far side keeps the unused trigger pin at a defined level
// [RQ20] pin operations start 2 us after the edge, plus two steps for margin or waveform
// [RQ21] busy flag set during waveform, margin or alarm update, cleared on completion
// [RQ22] pin goes through two flops, one single pulse per edge
// [RQ23] a running pin operation keeps its original mapping until done
`default_nettype none

module dgt_trigger_ctrl #(
    parameter int RESOLUTION = dgt_pkg::RESOLUTION_DEF,
    parameter int TIME_DIV = 1
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic trigger_input_pin_i,
    input wire logic trigger_input_enable_i,
    input wire logic [2:0] trigger_function_select_i,
    input wire logic [3:0] step_period_select_i,
    input wire logic nvm_ready_i,
    input wire logic [9:0] nvm_output_code_i,
    input wire logic [1:0] nvm_powerdown_mode_i,
    input wire logic nvm_vref_enable_i,
    input wire logic [1:0] nvm_gain_select_i,
    input wire logic cfg_write_i,
    input wire logic [9:0] cfg_output_code_i,
    input wire logic [1:0] cfg_powerdown_mode_i,
    input wire logic cfg_vref_enable_i,
    input wire logic [1:0] cfg_gain_select_i,
    input wire logic sw_cmd_valid_i,
    input wire logic [2:0] sw_cmd_func_i,
    input wire logic sw_cmd_level_i,
    input wire logic update_done_i,
    output logic booted_o,
    output logic [9:0] output_code_o,
    output logic [1:0] output_state_o,
    output logic vref_enable_o,
    output logic [2:0] output_gain_o,
    output logic [1:0] margin_sel_o,
    output logic func_gen_run_o,
    output logic alarm_run_o,
    output logic [1:0] alarm_priority_o,
    output logic addr_update_enable_o,
    output logic output_update_in_progress_o
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic needs_step(input logic [2:0] f);
        needs_step = (f == dgt_pkg::FS_MARGIN) || (f == dgt_pkg::FS_FUNCGEN);
    endfunction

    function automatic logic same_group(input logic [2:0] a, input logic [2:0] b);
        // both power functions share one software control
        if (a[2:1] == 2'h0 && b[2:1] == 2'h0) begin
            same_group = 1'b1;
        end else begin
            same_group = (a == b);
        end
    endfunction

    // periods above the table reuse the longest known entry
    function automatic logic [dgt_pkg::CNT_W-1:0] delay_cyc(input logic [2:0] f,
                                                           input logic [3:0] s);
        int idx;
        int cyc;
        idx = (int'(s) > dgt_pkg::STEP_LAST) ? dgt_pkg::STEP_LAST : int'(s);
        cyc = dgt_pkg::TRIG_DELAY_CYC;
        if (needs_step(f)) begin
            cyc = cyc + dgt_pkg::STEP_WAITS *
                  (dgt_pkg::STEP_NS[idx] / dgt_pkg::CLK_PERIOD_NS / TIME_DIV);
        end
        delay_cyc = dgt_pkg::CNT_W'(cyc - 1);
    endfunction

    function automatic logic [2:0] gain_of(input logic vref, input logic [1:0] g);
        if (!vref) begin
            gain_of = dgt_pkg::GAIN_1X;
        end else begin
            case (g)
                2'h0: gain_of = dgt_pkg::GAIN_1P5X;
                2'h1: gain_of = dgt_pkg::GAIN_2X;
                2'h2: gain_of = dgt_pkg::GAIN_3X;
                default: gain_of = dgt_pkg::GAIN_4X;
            endcase
        end
    endfunction

    function automatic logic [9:0] fit_code(input logic [9:0] c);
        fit_code = c & 10'((1 << RESOLUTION) - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin sampling

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    logic pin_level;
    logic pin_rise;
    logic pin_fall;

    // [RQ22] synchronise, single pulses
    dgt_edge_sync u_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .pin_i(trigger_input_pin_i),
        .level_o(pin_level),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // boot and pending trigger sequencer

    dgt_pkg::dgt_boot_t boot, next_boot;
    logic pend, next_pend;
    logic [2:0] pend_func, next_pend_func;
    logic pend_level, next_pend_level;
    logic [dgt_pkg::CNT_W-1:0] cnt, next_cnt;
    logic q_valid, next_q_valid;
    logic q_level, next_q_level;
    logic edge_ok;
    logic exec_now;

    // [RQ8] enable gates every pin edge
    // [RQ9] only edges act once running
    assign edge_ok = (pin_rise | pin_fall) & trigger_input_enable_i & (boot == dgt_pkg::BOOT_RUN);
    // [RQ20] operation starts when the wait ends
    assign exec_now = pend & (cnt == '0);

    always_comb begin
        next_boot = boot;
        next_pend = pend;
        next_pend_func = pend_func;
        next_pend_level = pend_level;
        next_cnt = cnt;
        next_q_valid = q_valid;
        next_q_level = q_level;
        if (pend && cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
        if (exec_now) begin
            next_pend = 1'b0;
        end
        case (boot)
            dgt_pkg::BOOT_LOAD: begin
                // [RQ2] wait for stored settings
                if (nvm_ready_i) begin
                    next_boot = dgt_pkg::BOOT_SAMPLE;
                end
            end
            dgt_pkg::BOOT_SAMPLE: begin
                next_boot = dgt_pkg::BOOT_RUN;
                // [RQ10] power-up level runs its command
                if (trigger_input_enable_i) begin
                    next_pend = 1'b1;
                    next_pend_func = trigger_function_select_i;
                    next_pend_level = pin_level;
                    next_cnt = delay_cyc(trigger_function_select_i, step_period_select_i);
                end
            end
            dgt_pkg::BOOT_RUN: begin
                // [RQ23] one later edge waits for the running one, a newer edge replaces it
                if (edge_ok && pend && !exec_now) begin
                    next_q_valid = 1'b1;
                    next_q_level = pin_rise;
                end else if (edge_ok || (exec_now && q_valid && trigger_input_enable_i)) begin
                    next_pend = 1'b1;
                    next_pend_func = trigger_function_select_i;
                    next_pend_level = edge_ok ? pin_rise : q_level;
                    next_cnt = delay_cyc(trigger_function_select_i, step_period_select_i);
                    next_q_valid = 1'b0;
                end
                if (!trigger_input_enable_i) begin
                    next_q_valid = 1'b0;
                end
            end
            default: next_boot = dgt_pkg::BOOT_LOAD;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            boot <= dgt_pkg::BOOT_LOAD;
            pend <= 1'b0;
            pend_func <= dgt_pkg::FS_PD_HIZ;
            pend_level <= 1'b0;
            cnt <= '0;
            q_valid <= 1'b0;
            q_level <= 1'b0;
        end else begin
            boot <= next_boot;
            pend <= next_pend;
            pend_func <= next_pend_func;
            pend_level <= next_pend_level;
            cnt <= next_cnt;
            q_valid <= next_q_valid;
            q_level <= next_q_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output state and actions

    logic [9:0] code, next_code;
    logic [1:0] ostate, next_ostate;
    logic vref, next_vref;
    logic [1:0] gsel, next_gsel;
    logic [2:0] gain, next_gain;
    logic [1:0] margin, next_margin;
    logic fg_run, next_fg_run;
    logic alm_run, next_alm_run;
    logic [1:0] alm_prio, next_alm_prio;
    logic addr_upd, next_addr_upd;
    logic busy, next_busy;
    logic sw_conflict;
    logic sw_take;
    logic cfg_pdn_take;
    logic [1:0] act_v;
    logic [2:0] act_f [2];
    logic [1:0] act_l;

    // [RQ11] mapped function locks out its software twin
    assign sw_conflict = trigger_input_enable_i & same_group(sw_cmd_func_i, trigger_function_select_i);
    assign sw_take = sw_cmd_valid_i & (boot == dgt_pkg::BOOT_RUN) & ~sw_conflict;
    assign cfg_pdn_take = cfg_write_i & (boot == dgt_pkg::BOOT_RUN) &
                          ~(trigger_input_enable_i & (trigger_function_select_i[2:1] == 2'h0));

    // pin action applied last so it wins over software
    assign act_v = {exec_now, sw_take};
    assign act_f[0] = sw_cmd_func_i;
    assign act_f[1] = pend_func;
    assign act_l = {pend_level, sw_cmd_level_i};

    always_comb begin
        next_code = code;
        next_ostate = ostate;
        next_vref = vref;
        next_gsel = gsel;
        next_margin = margin;
        next_fg_run = fg_run;
        next_alm_run = alm_run;
        next_alm_prio = alm_prio;
        next_addr_upd = addr_upd;
        next_busy = busy;
        if (boot == dgt_pkg::BOOT_LOAD && nvm_ready_i) begin
            // [RQ2] load stored settings
            next_code = fit_code(nvm_output_code_i);
            // [RQ3] stored mode picks power-on state
            next_ostate = (nvm_powerdown_mode_i == dgt_pkg::PDN_RGND) ? dgt_pkg::PDN_RGND
                                                                      : dgt_pkg::PDN_HIZ;
            next_vref = nvm_vref_enable_i;
            next_gsel = nvm_gain_select_i;
        end else if (cfg_write_i && boot == dgt_pkg::BOOT_RUN) begin
            // [RQ4] code kept within resolution
            next_code = fit_code(cfg_output_code_i);
            // [RQ6] reference enable bit
            next_vref = cfg_vref_enable_i;
            next_gsel = cfg_gain_select_i;
        end
        if (cfg_pdn_take) begin
            next_ostate = cfg_powerdown_mode_i;
        end
        // busy clears on completion while no waveform or alarm runs, a new start below wins
        if (update_done_i) begin
            next_margin = dgt_pkg::MRG_NONE;
            if (!fg_run && !alm_run) begin
                next_busy = 1'b0;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (act_v[i]) begin
                case (act_f[i])
                    // [RQ13] power up or down
                    dgt_pkg::FS_PD_HIZ: next_ostate = act_l[i] ? dgt_pkg::PDN_ON : dgt_pkg::PDN_HIZ;
                    dgt_pkg::FS_PD_RGND: next_ostate = act_l[i] ? dgt_pkg::PDN_ON
                                                               : dgt_pkg::PDN_RGND;
                    // [RQ14] margin and waveform
                    // [RQ12] each margin request retargets
                    dgt_pkg::FS_MARGIN: begin
                        next_margin = act_l[i] ? dgt_pkg::MRG_HIGH : dgt_pkg::MRG_LOW;
                        // [RQ21] margin transition busy
                        next_busy = 1'b1;
                    end
                    dgt_pkg::FS_FUNCGEN: begin
                        next_fg_run = act_l[i];
                        next_busy = next_busy | act_l[i];
                    end
                    // [RQ18] address update gate
                    dgt_pkg::FS_ADDR: next_addr_upd = act_l[i];
                    default: begin
                        // [RQ15] [RQ16] [RQ17] alarm start and stop
                        next_alm_run = act_l[i];
                        next_alm_prio = act_l[i] ? (act_f[i] == dgt_pkg::FS_ALARM_HI ? dgt_pkg::ALM_HI :
                                        act_f[i] == dgt_pkg::FS_ALARM_MED ? dgt_pkg::ALM_MED :
                                        dgt_pkg::ALM_LO) : dgt_pkg::ALM_NONE;
                        next_busy = next_busy | act_l[i];
                    end
                endcase
            end
        end
        // [RQ5] [RQ7] gain from reference and select
        next_gain = gain_of(next_vref, next_gsel);
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            code <= dgt_pkg::RST_CODE;
            ostate <= dgt_pkg::RST_PDN;
            vref <= 1'b0;
            gsel <= 2'h0;
            gain <= dgt_pkg::RST_GAIN;
            margin <= dgt_pkg::MRG_NONE;
            fg_run <= 1'b0;
            alm_run <= 1'b0;
            alm_prio <= dgt_pkg::ALM_NONE;
            addr_upd <= 1'b0;
            busy <= 1'b0;
        end else begin
            code <= next_code;
            ostate <= next_ostate;
            vref <= next_vref;
            gsel <= next_gsel;
            gain <= next_gain;
            margin <= next_margin;
            fg_run <= next_fg_run;
            alm_run <= next_alm_run;
            alm_prio <= next_alm_prio;
            addr_upd <= next_addr_upd;
            busy <= next_busy;
        end
    end

    assign booted_o = (boot == dgt_pkg::BOOT_RUN);
    assign output_code_o = code;
    assign output_state_o = ostate;
    assign vref_enable_o = vref;
    assign output_gain_o = gain;
    assign margin_sel_o = margin;
    assign func_gen_run_o = fg_run;
    assign alarm_run_o = alm_run;
    assign alarm_priority_o = alm_prio;
    assign addr_update_enable_o = addr_upd;
    assign output_update_in_progress_o = busy;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_GATE_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ8]
        (!pend && !trigger_input_enable_i) |=> !pend)
        else $error("trigger acted while disabled");

    AST_BOOT_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ2]
        (boot == dgt_pkg::BOOT_LOAD && nvm_ready_i) |=>
        (code == fit_code($past(nvm_output_code_i))) && (boot == dgt_pkg::BOOT_SAMPLE))
        else $error("stored settings not loaded");

    AST_HIZ_DEFAULT: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ3]
        (boot == dgt_pkg::BOOT_LOAD) |-> (ostate == dgt_pkg::PDN_HIZ) && !vref)
        else $error("output not high impedance before load");

    AST_GAIN_UNITY: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ5]
        !vref |-> (gain == dgt_pkg::GAIN_1X))
        else $error("gain not unity on supply reference");

    AST_SW_BLOCK: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ11]
        (booted_o && sw_cmd_valid_i && sw_conflict && !exec_now && !cfg_write_i &&
         !update_done_i) |=>
        $stable(ostate) && $stable(fg_run) && $stable(alm_run) && $stable(addr_upd))
        else $error("mapped software command took effect");

    AST_EDGE_ONLY: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ9]
        (boot == dgt_pkg::BOOT_RUN && !exec_now && !sw_cmd_valid_i && !cfg_write_i) |=>
        $stable(ostate) && $stable(fg_run) && $stable(addr_upd))
        else $error("output changed without an edge");

    AST_PIN_DELAY: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ20]
        ($rose(pend) && !needs_step(pend_func)) |-> ##249 exec_now)
        else $error("pin operation not started 2 us after edge");

    AST_STEP_WAIT: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ20]
        ($rose(pend) && needs_step(pend_func)) |-> !exec_now [*8])
        else $error("margin or waveform started without step wait");

    AST_BUSY_SET: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ21]
        (fg_run || alm_run || $rose(margin == dgt_pkg::MRG_HIGH)) |-> busy)
        else $error("busy flag missing during update");

    AST_ONE_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ22]
        (pin_rise |=> !pin_rise) and (pin_fall |=> !pin_fall))
        else $error("edge pulse longer than one cycle");

    AST_MAP_HELD: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ23]
        (pend && $past(pend) && !$past(exec_now)) |-> $stable(pend_func))
        else $error("running operation lost its mapping");

    AST_POWER_UP: assert property (@(posedge mclk_i) disable iff (!rst_n) // [RQ13]
        (exec_now && pend_level && pend_func[2:1] == 2'h0) |=> (ostate == dgt_pkg::PDN_ON))
        else $error("rising edge did not power up");

endmodule // dgt_trigger_ctrl

`default_nettype wire

// >>> test/dgt_far_model.sv
`default_nettype none
module dgt_far_model (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic done_req_i,
    input wire logic [7:0] done_dly_i,
    output logic nvm_ready_o,
    output logic [9:0] nvm_code_o,
    output logic [1:0] nvm_pdn_o,
    output logic nvm_vref_o,
    output logic [1:0] nvm_gain_o,
    output logic update_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] boot_cnt;
    logic [7:0] done_cnt;
    assign nvm_code_o = 10'h2A5;
    assign nvm_pdn_o = dgt_pkg::PDN_RGND;
    // reference stays off; stored gain must be ignored
    assign nvm_vref_o = 1'b0;
    assign nvm_gain_o = 2'h3;
    assign nvm_ready_o = (boot_cnt == 8'h10);
    assign update_done_o = (done_cnt == 8'h01);
    ////////////////////////////////////////////////////////////////////////////
    // memory slow to settle; slew engine answers after a chosen delay
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_cnt <= 8'h00;
            done_cnt <= 8'h00;
        end else begin
            if (boot_cnt != 8'h10) boot_cnt <= boot_cnt + 8'h01;
            if (done_req_i) done_cnt <= done_dly_i;
            else if (done_cnt != 8'h00) done_cnt <= done_cnt - 8'h01;
        end
    end
endmodule // dgt_far_model
`default_nettype wire

// >>> test/dgt_trigger_ctrl_tb.sv
`default_nettype none
module dgt_trigger_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, pin = 1'b0, en = 1'b0, wr = 1'b0, vref = 1'b0;
    logic sw_v = 1'b0, sw_l = 1'b1, dreq = 1'b0, rdy, udone, booted, vref_o, fg, alm, aen, busy;
    logic [2:0] fs = 3'h7, sw_f = 3'h0, gain;
    logic [1:0] gsel = 2'h0, cpd = dgt_pkg::PDN_HIZ, npd, ngn, state, mrg, prio;
    logic [9:0] ccode = 10'h3FF, ncode, code;
    logic [7:0] dly = 8'h1E;
    logic [3:0] sps = 4'h0;
    logic nvref;
    int n_mismatch = 0, cmp_count = 0;
    dgt_far_model i_dgt_far_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .done_req_i(dreq),
        .done_dly_i(dly), .nvm_ready_o(rdy), .nvm_code_o(ncode), .nvm_pdn_o(npd),
        .nvm_vref_o(nvref), .nvm_gain_o(ngn), .update_done_o(udone));
    // short step periods keep the run brief
    dgt_trigger_ctrl #(.RESOLUTION(10), .TIME_DIV(64)) i_dgt_trigger_ctrl (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .trigger_input_pin_i(pin), .trigger_input_enable_i(en),
        .trigger_function_select_i(fs), .step_period_select_i(sps), .nvm_ready_i(rdy),
        .nvm_output_code_i(ncode), .nvm_powerdown_mode_i(npd), .nvm_vref_enable_i(nvref),
        .nvm_gain_select_i(ngn), .cfg_write_i(wr), .cfg_output_code_i(ccode),
        .cfg_powerdown_mode_i(cpd), .cfg_vref_enable_i(vref), .cfg_gain_select_i(gsel),
        .sw_cmd_valid_i(sw_v), .sw_cmd_func_i(sw_f), .sw_cmd_level_i(sw_l),
        .update_done_i(udone), .booted_o(booted), .output_code_o(code),
        .output_state_o(state), .vref_enable_o(vref_o), .output_gain_o(gain),
        .margin_sel_o(mrg), .func_gen_run_o(fg), .alarm_run_o(alm),
        .alarm_priority_o(prio), .addr_update_enable_o(aen),
        .output_update_in_progress_o(busy));
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic rst();
        reset_n_i = 1'b0;
        cyc(12);
        reset_n_i = 1'b1;
        for (int i = 0; i < 100 && booted !== 1'b1; i++) cyc(1);
    endtask
    // pin always held at a defined level
    task automatic trig(input logic [2:0] f, input logic l, input int n);
        fs = f;
        en = 1'b1;
        pin = l;
        cyc(n);
    endtask
    task automatic upd_done();
        dreq = 1'b1;
        cyc(1);
        dreq = 1'b0;
        cyc(40);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst();
        chk("booted", 10'h001, 10'(booted));
        chk("code", 10'h2A5, code);
        chk("state", 10'(dgt_pkg::PDN_RGND), 10'(state));
        chk("vref", 10'h000, 10'(vref_o));
        chk("gain", 10'(dgt_pkg::GAIN_1X), 10'(gain));
        $display("test boot done");
        for (int g = 0; g < 5; g++) begin
            vref = (g < 4);
            gsel = 2'(g);
            wr = 1'b1;
            cyc(1);
            wr = 1'b0;
            cyc(1);
            chk("gain", (g < 4) ? 10'(g + 1) : 10'h000, 10'(gain));
            chk("vref", 10'(vref), 10'(vref_o));
            chk("code", 10'h3FF, code);
        end
        chk("state", 10'(dgt_pkg::PDN_HIZ), 10'(state));
        $display("test config done");
        fs = 3'h0;
        pin = 1'b1;
        cyc(300);
        chk("state", 10'(dgt_pkg::PDN_HIZ), 10'(state));
        pin = 1'b0;
        cyc(10);
        trig(3'h0, 1'b1, 240);
        chk("state", 10'(dgt_pkg::PDN_HIZ), 10'(state));
        cyc(20);
        chk("state", 10'(dgt_pkg::PDN_ON), 10'(state));
        trig(3'h0, 1'b0, 300);
        chk("state", 10'(dgt_pkg::PDN_HIZ), 10'(state));
        trig(3'h1, 1'b1, 300);
        trig(3'h1, 1'b0, 300);
        chk("state", 10'(dgt_pkg::PDN_RGND), 10'(state));
        sw_f = 3'h0;
        sw_v = 1'b1;
        cyc(1);
        sw_f = 3'h7;
        cyc(1);
        sw_v = 1'b0;
        cyc(2);
        chk("state", 10'(dgt_pkg::PDN_RGND), 10'(state));
        chk("addr", 10'h001, 10'(aen));
        trig(3'h7, 1'b1, 300);
        trig(3'h7, 1'b0, 300);
        chk("addr", 10'h000, 10'(aen));
        sw_v = 1'b1;
        cyc(1);
        sw_v = 1'b0;
        cyc(1);
        chk("addr", 10'h000, 10'(aen));
        trig(3'h7, 1'b1, 300);
        chk("addr", 10'h001, 10'(aen));
        trig(3'h7, 1'b0, 300);
        chk("addr", 10'h000, 10'(aen));
        $display("test power and address done");
        for (int k = 0; k < 3; k++) begin
            trig(3'(4 + k), 1'b1, 300);
            chk("alarm", 10'h001, 10'(alm));
            chk("prio", 10'(3 - k), 10'(prio));
            chk("busy", 10'h001, 10'(busy));
            trig(3'(4 + k), 1'b0, 300);
            chk("alarm", 10'h000, 10'(alm));
            upd_done();
            chk("busy", 10'h000, 10'(busy));
        end
        $display("test alarms done");
        dly = 8'h02;
        trig(3'h2, 1'b1, 330);
        chk("margin", 10'(dgt_pkg::MRG_NONE), 10'(mrg));
        cyc(30);
        chk("margin", 10'(dgt_pkg::MRG_HIGH), 10'(mrg));
        chk("busy", 10'h001, 10'(busy));
        upd_done();
        sps = 4'h1;
        trig(3'h2, 1'b0, 365);
        chk("margin", 10'(dgt_pkg::MRG_NONE), 10'(mrg));
        cyc(35);
        chk("margin", 10'(dgt_pkg::MRG_LOW), 10'(mrg));
        upd_done();
        chk("busy", 10'h000, 10'(busy));
        trig(3'h3, 1'b1, 400);
        chk("funcgen", 10'h001, 10'(fg));
        trig(3'h3, 1'b0, 400);
        chk("funcgen", 10'h000, 10'(fg));
        $display("test margin and waveform done");
        fs = 3'h0;
        pin = 1'b1;
        rst();
        cyc(300);
        chk("state", 10'(dgt_pkg::PDN_ON), 10'(state));
        $display("test power-up sample done");
        print_verdict();
    end
    // hang guard, well beyond the expected run length
    initial begin
        cyc(20000);
        n_mismatch++;
        print_verdict();
    end
endmodule // dgt_trigger_ctrl_tb
`default_nettype wire
